/* rtl/tmr_unit.sv */
// Purpose: three 16-bit timers sharing one counter element, with pin control
// Assumes: pins synchronous to mclk after the two-stage synchroniser
// Notes: timer 2 has no pins; ctrl bits not used by timer 2 read zero
// Operation
// [R1] internal clock advances count every fourth clock
// [R2] timer two counts only the internal clock
// [R3] ext and prescale clear select internal clock
// [R4] prescale set counts timer two wraps
// [R5] software starts timer two before chaining
// [R6] pin rising edges synchronised and latched
// [R7] count only a low then high transition
// [R8] external edges no faster than quarter clock
// [R9] latched edge held until timer serviced
// [R10] pin events count only while run set
// [R11] level gate: count while pin high
// [R12] retrigger mode: rising edge clears count
// [R13] retrigger mode waits for first edge
// [R14] retrigger keeps active limit register
// [R15] cycle end halts unless repeat set
// [R16] single limit: one-clock low output pulse
// [R17] dual limit: output low while B active
// [R18] halted timer drives output high; a dual limit timer stopped by software in its B phase with alt still set keeps its output low
// [R19] pin to output latency 2.5 to 6 clocks
// [R20] output pins always driven
// [R21] equality with limit resets count; zero=65536
// [R22] dual limit alternates A then B
`timescale 1ns/10ps
module tmr_unit (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer pins
  input wire logic [1:0] tin,
  output logic [1:0] timer_output_pin
);

  // register banks
  logic [15:0] cnt_q [3];
  logic [15:0] cnt_d [3];
  logic [15:0] cmpa_q [3];
  logic [15:0] cmpa_d [3];
  logic [15:0] cmpb_q [3];
  logic [15:0] cmpb_d [3];
  tmr_pkg::tctl_t ctl_q [3];
  tmr_pkg::tctl_t ctl_d [3];
  // per-timer event state; bit 2 stays zero except pulse_d, timer 2 has no pin
  logic [2:0] s1_q, s2_q, s3_q; // pin synchroniser and edge history
  logic [2:0] edge_q, edge_d; // latched rising edge awaiting service
  logic [2:0] tick_q, tick_d; // pending timer-2 wrap for chained counting
  logic [2:0] arm_q, arm_d; // retrigger mode has seen its first edge
  logic [2:0] pulse_d; // end-of-cycle pulse request
  logic [1:0] tout_q, tout_d;
  logic [2:0] rise; // fresh synchronised rising edge
  // counter element sequencing
  tmr_pkg::slot_t slot_q, slot_d;
  // bus state
  tmr_pkg::bus_req_t req_q, req_d;
  logic [31:0] rdat_q, rdat_d;
  logic accept;
  logic [7:0] aidx;
  logic mapped;
  logic [31:0] rd_word;

  // base index of a timer's bank
  function automatic logic [7:0] base_idx(input int t);
    if (t == 0) begin
      return tmr_pkg::IDX_T0_CNT;
    end else if (t == 1) begin
      return tmr_pkg::IDX_T1_CNT;
    end
    return tmr_pkg::IDX_T2_CNT;
  endfunction

  // control word as read; inhibit is never stored and reads zero
  function automatic logic [31:0] pack_ctl(input tmr_pkg::tctl_t c, input logic t2);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tmr_pkg::B_EN] = c.en;
    w[tmr_pkg::B_INT] = c.intr;
    w[tmr_pkg::B_MC] = c.mc;
    w[tmr_pkg::B_CONT] = c.cont;
    if (!t2) begin
      w[tmr_pkg::B_LIMIT_B_ACTIVE] = c.limit_b_active;
      w[tmr_pkg::B_RESTART_ON_EDGE] = c.restart_on_edge;
      w[tmr_pkg::B_P] = c.p;
      w[tmr_pkg::B_EXT] = c.ext;
      w[tmr_pkg::B_ALT] = c.alt;
    end
    return w;
  endfunction

  // control write: run bit only moves with inhibit set, active-limit flag is read only
  function automatic tmr_pkg::tctl_t wr_ctl(input tmr_pkg::tctl_t o, input logic [31:0] d,
                                            input logic t2);
    tmr_pkg::tctl_t c;
    c = o;
    if (d[tmr_pkg::B_INH]) begin
      c.en = d[tmr_pkg::B_EN];
    end
    c.intr = d[tmr_pkg::B_INT];
    c.mc = d[tmr_pkg::B_MC];
    c.cont = d[tmr_pkg::B_CONT];
    c.alt = t2 ? 1'b0 : d[tmr_pkg::B_ALT];
    c.restart_on_edge = t2 ? 1'b0 : d[tmr_pkg::B_RESTART_ON_EDGE];
    c.p = t2 ? 1'b0 : d[tmr_pkg::B_P];
    c.ext = t2 ? 1'b0 : d[tmr_pkg::B_EXT];
    return c;
  endfunction

  // address phase decode
  assign accept = hsel & htrans[1] & hready & ce;
  assign aidx = haddr[9:2];
  assign hreadyout = ce; // no wait states; a frozen block stalls the bus
  assign hresp = 1'b0; // always okay
  assign hrdata = rdat_q;
  assign timer_output_pin = tout_q; // [R20]

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = (haddr[31:10] == 22'h00_0000);
    for (int i = 0; i < 3; i++) begin
      if (!mapped) begin
        rd_word = rd_word;
      end else if (aidx == base_idx(i)) begin
        rd_word = {16'h0000, cnt_q[i]};
      end else if (aidx == base_idx(i) + tmr_pkg::OFS_CMPA) begin
        rd_word = {16'h0000, cmpa_q[i]};
      end else if (aidx == base_idx(i) + tmr_pkg::OFS_CMPB && i < 2) begin
        rd_word = {16'h0000, cmpb_q[i]};
      end else if (aidx == base_idx(i) + tmr_pkg::OFS_CON) begin
        rd_word = pack_ctl(ctl_q[i], i == 2);
      end
    end
  end

  // bus next state: capture address phase, read data ready for data phase
  always_comb begin
    req_d = '0;
    rdat_d = rdat_q;
    if (accept) begin
      req_d.valid = mapped;
      req_d.write = hwrite;
      req_d.idx = aidx;
      rdat_d = hwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      req_q <= '0;
      rdat_q <= 32'h0000_0000;
    end else if (ce) begin
      req_q <= req_d;
      rdat_q <= rdat_d;
    end
  end

  // counter element walks the three banks, then one idle slot
  always_comb begin
    case (slot_q)
      tmr_pkg::SLOT_T0: slot_d = tmr_pkg::SLOT_T1;
      tmr_pkg::SLOT_T1: slot_d = tmr_pkg::SLOT_T2;
      tmr_pkg::SLOT_T2: slot_d = tmr_pkg::SLOT_IDLE;
      default: slot_d = tmr_pkg::SLOT_T0; // [R1]
    endcase
  end

  // pin edges: only synchronised low-to-high steps count
  assign rise = s2_q & ~s3_q; // [R7]

  // timer next state: bus write first, then the serviced timer on top
  always_comb begin
    tmr_pkg::tctl_t c;
    logic [15:0] inc;
    logic [15:0] lim;
    logic evt;
    logic fin;
    c = '0;
    inc = 16'h0000;
    lim = 16'h0000;
    evt = 1'b0;
    fin = 1'b0;
    pulse_d = 3'b000;
    tick_d = tick_q;
    arm_d = arm_q;
    for (int i = 0; i < 3; i++) begin
      cnt_d[i] = cnt_q[i];
      cmpa_d[i] = cmpa_q[i];
      cmpb_d[i] = cmpb_q[i];
      ctl_d[i] = ctl_q[i];
      // software access, data phase
      if (req_q.valid && req_q.write) begin
        if (req_q.idx == base_idx(i)) begin
          cnt_d[i] = hwdata[15:0];
        end else if (req_q.idx == base_idx(i) + tmr_pkg::OFS_CMPA) begin
          cmpa_d[i] = hwdata[15:0];
        end else if (req_q.idx == base_idx(i) + tmr_pkg::OFS_CMPB && i < 2) begin
          cmpb_d[i] = hwdata[15:0];
        end else if (req_q.idx == base_idx(i) + tmr_pkg::OFS_CON) begin
          ctl_d[i] = wr_ctl(ctl_q[i], hwdata, i == 2);
        end
      end
    end
    // edges wait here until their timer's slot; ignored while stopped
    edge_d = (edge_q | rise) & {ctl_q[2].en, ctl_q[1].en, ctl_q[0].en}; // [R6] [R9]
    for (int i = 0; i < 3; i++) begin
      if ((i == 0 && slot_q == tmr_pkg::SLOT_T0) || (i == 1 && slot_q == tmr_pkg::SLOT_T1) ||
          (i == 2 && slot_q == tmr_pkg::SLOT_T2)) begin
        c = ctl_d[i];
        evt = 1'b0;
        edge_d[i] = rise[i] & c.en; // consumed; a new edge this cycle survives
        tick_d[i] = 1'b0;
        if (!c.en) begin
          arm_d[i] = 1'b0;
        end else if (i < 2 && !c.ext && c.restart_on_edge && edge_q[i]) begin
          // retrigger: restart the current limit, active limit untouched
          cnt_d[i] = 16'h0000; // [R12] [R14]
          arm_d[i] = 1'b1; // [R13]
        end else begin
          if (i == 2) begin
            evt = 1'b1; // [R2]
          end else if (c.ext) begin
            evt = edge_q[i]; // [R10]
          end else begin
            // [R3] [R4] [R11] [R13]
            evt = (c.p ? tick_q[i] : 1'b1) & (c.restart_on_edge ? arm_q[i] : s2_q[i]);
          end
          if (evt) begin
            inc = cnt_d[i] + 16'h0001;
            lim = c.limit_b_active ? cmpb_d[i] : cmpa_d[i];
            if (inc == lim) begin
              // a zero limit matches on the wrap from FFFF
              cnt_d[i] = 16'h0000; // [R21]
              c.mc = 1'b1;
              fin = !c.alt || c.limit_b_active;
              c.limit_b_active = c.alt & ~c.limit_b_active; // [R22]
              pulse_d[i] = ~c.alt; // [R16]
              if (i == 2) begin
                tick_d[1:0] = 2'b11; // [R4]
              end
              if (fin && !c.cont) begin
                c.en = 1'b0; // [R15]
                c.limit_b_active = 1'b0; // [R18]
                arm_d[i] = 1'b0;
              end
            end else begin
              cnt_d[i] = inc;
            end
          end
        end
        ctl_d[i] = c;
      end
      if (!ctl_d[i].alt) begin
        ctl_d[i].limit_b_active = 1'b0;
      end
    end
    // output level: B active low, pulse low for one clock, else high
    for (int i = 0; i < 2; i++) begin
      tout_d[i] = ~((ctl_d[i].alt & ctl_d[i].limit_b_active) |
                    pulse_d[i]); // [R16] [R17] [R18] [R19]
    end
  end

  // timer state registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slot_q <= tmr_pkg::SLOT_T0;
      s1_q <= 3'b000;
      s2_q <= 3'b000;
      s3_q <= 3'b000;
      edge_q <= 3'b000;
      tick_q <= 3'b000;
      arm_q <= 3'b000;
      tout_q <= 2'b11;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= tmr_pkg::CNT_RST;
        cmpa_q[i] <= tmr_pkg::CMP_RST;
        cmpb_q[i] <= tmr_pkg::CMP_RST;
        ctl_q[i] <= '0;
      end
    end else if (ce) begin
      slot_q <= slot_d;
      s1_q <= {1'b0, tin}; // [R6]
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_q <= edge_d;
      tick_q <= tick_d;
      arm_q <= arm_d;
      tout_q <= tout_d;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= cnt_d[i];
        cmpa_q[i] <= cmpa_d[i];
        cmpb_q[i] <= cmpb_d[i];
        ctl_q[i] <= ctl_d[i];
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_slot_period: assert property ( // [R1]
    slot_q == tmr_pkg::SLOT_T0 && ce ##1 ce[*3] |=> slot_q == tmr_pkg::SLOT_T0)
    else $error("service slot period is not four clocks");

  chk_t2_own_slot: assert property ( // [R2]
    $changed(cnt_q[2]) |-> $past(slot_q) == tmr_pkg::SLOT_T2 || $past(req_q.valid))
    else $error("timer 2 counted outside its slot");

  chk_chain_needs_tick: assert property ( // [R4]
    slot_q == tmr_pkg::SLOT_T0 && ce && !req_q.valid && ctl_q[0].p && !ctl_q[0].ext &&
    !ctl_q[0].restart_on_edge && !tick_q[0] |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("chained timer counted without a timer 2 wrap");

  chk_stopped_hold: assert property ( // [R10]
    slot_q == tmr_pkg::SLOT_T1 && ce && !req_q.valid && !ctl_q[1].en |=>
    cnt_q[1] == $past(cnt_q[1]))
    else $error("stopped timer changed its count");

  chk_gate_low_hold: assert property ( // [R11]
    slot_q == tmr_pkg::SLOT_T0 && ce && !req_q.valid && !ctl_q[0].ext &&
    !ctl_q[0].restart_on_edge && !s2_q[0] |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("gated timer counted with pin low");

  chk_retrig_clear: assert property ( // [R12]
    slot_q == tmr_pkg::SLOT_T1 && ce && !req_q.valid && ctl_q[1].en && !ctl_q[1].ext &&
    ctl_q[1].restart_on_edge && edge_q[1] |=> cnt_q[1] == 16'h0000 && arm_q[1])
    else $error("retrigger edge did not clear the count");

  chk_edge_held: assert property ( // [R9]
    edge_q[1] && ctl_q[1].en && ce && slot_q != tmr_pkg::SLOT_T1 && !req_q.valid |=> edge_q[1])
    else $error("latched edge lost before service");

  chk_pulse_width: assert property ( // [R16]
    $fell(tout_q[0]) && !ctl_q[0].alt && ce |=> tout_q[0])
    else $error("end-of-cycle pulse longer than one clock");

  chk_dual_level: assert property ( // [R17]
    ctl_q[0].alt |-> tout_q[0] == !ctl_q[0].limit_b_active)
    else $error("dual limit output does not follow active register");

  chk_halt_high: assert property ( // [R18]
    !ctl_q[0].en && !$past(ctl_q[0].en) |-> tout_q[0])
    else $error("halted timer output not high");

  cov_retrigger: cover property (slot_q == tmr_pkg::SLOT_T1 && ctl_q[1].restart_on_edge &&
    edge_q[1] && ctl_q[1].en);
  cov_dual_wave: cover property (ctl_q[0].alt && $fell(tout_q[0]) ##[1:400] $rose(tout_q[0]));
  cov_chain_tick: cover property (tick_q[0] && slot_q == tmr_pkg::SLOT_T0 && ctl_q[0].p);
  cov_halt: cover property ($fell(ctl_q[0].en) && !req_q.valid);

endmodule

/* inc/tmr_pkg.sv */
// Purpose: shared constants and types for the three-timer event and pin block
// Assumes: AHB-Lite register access, one aligned word per register index
// Notes: byte address of a register is four times its index
package tmr_pkg;
  // register indices; byte address = 4 * index
  localparam logic [7:0] IDX_T0_CNT = 8'h30;
  localparam logic [7:0] IDX_T1_CNT = 8'h38;
  localparam logic [7:0] IDX_T2_CNT = 8'h40;
  localparam logic [7:0] OFS_CMPA = 8'h02;
  localparam logic [7:0] OFS_CMPB = 8'h04;
  localparam logic [7:0] OFS_CON = 8'h06;
  // control word bit positions
  localparam int B_CONT = 0;
  localparam int B_ALT = 1;
  localparam int B_EXT = 2;
  localparam int B_P = 3;
  localparam int B_RESTART_ON_EDGE = 4;
  localparam int B_MC = 5;
  localparam int B_LIMIT_B_ACTIVE = 12;
  localparam int B_INT = 13;
  localparam int B_INH = 14;
  localparam int B_EN = 15;
  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // timing: clock period and the pin-to-output latency window
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_CYCLES = 4;
  localparam int LAT_MIN_PS = 25000;
  localparam int LAT_MAX_PS = 60000;
  localparam int LAT_MIN_CYC = (LAT_MIN_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
  localparam int LAT_MAX_CYC = LAT_MAX_PS / (CLK_PERIOD_NS * 1000);
  // counter element service slots
  typedef enum logic [3:0] {
    SLOT_T0 = 4'b0001,
    SLOT_T1 = 4'b0010,
    SLOT_T2 = 4'b0100,
    SLOT_IDLE = 4'b1000
  } slot_t;
  // stored control state of one timer
  typedef struct packed {
    logic en;
    logic intr;
    logic limit_b_active;
    logic mc;
    logic restart_on_edge;
    logic p;
    logic ext;
    logic alt;
    logic cont;
  } tctl_t;
  // captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } bus_req_t;
endpackage

/* dv/tin_src.sv */
// Purpose: far-side model: event sources on the timer inputs, loads on the outputs
// Assumes: inputs rest high after a pulse train until level drives them low; outputs always driven by the block
// Notes: lat holds edges from the last timer 1 input rise to the next timer 1 output fall
`timescale 1ns/10ps
module tin_src (
  // clock
  input wire logic mclk,
  // pins
  input wire logic [1:0] top,
  output logic [1:0] tin
);
  logic [1:0] prev_q; // input levels one edge back
  logic top_q; // timer 1 output one edge back
  int since; // edges since the last timer 1 input rise
  int lat; // captured input-to-output latency
  initial begin
    tin = 2'b00;
    prev_q = 2'b00;
    top_q = 1'b1;
    since = 0;
    lat = 0;
  end
  // latency probe: restart on an input rise, capture on an output fall
  always @(posedge mclk) begin
    prev_q <= tin;
    top_q <= top[1];
    if (tin[1] && !prev_q[1]) begin
      since <= 0;
    end else begin
      since <= since + 1;
    end
    if (top_q && !top[1]) begin
      lat <= since;
    end
  end
  // hold an input at a steady level, as a gate source would
  task automatic level(input int idx, input logic v);
    @(posedge mclk);
    tin[idx] <= v;
  endtask
  // low then high, each phase at least two clocks, so edges are four or more apart
  task automatic pulses(input int idx, input int n, input int lo, input int hi);
    repeat (n) begin
      @(posedge mclk);
      tin[idx] <= 1'b0;
      repeat (lo) @(posedge mclk);
      tin[idx] <= 1'b1;
      repeat (hi - 1) @(posedge mclk);
    end
  endtask
endmodule

/* dv/timer_event_pin_control_test.sv */
// Purpose: self-checking bench for the three-timer event and pin block
// Assumes: one AHB-Lite master, zero wait states expected but not assumed
// Notes: results are queued expectations compared by a separate watcher
`timescale 1ns/10ps
module timer_event_pin_control_test;
  localparam logic [7:0] T0 = tmr_pkg::IDX_T0_CNT; // timer 0 bank
  localparam logic [7:0] T1 = tmr_pkg::IDX_T1_CNT; // timer 1 bank
  localparam logic [7:0] T2 = tmr_pkg::IDX_T2_CNT; // timer 2 bank
  localparam logic [7:0] A = tmr_pkg::OFS_CMPA;
  localparam logic [7:0] B = tmr_pkg::OFS_CMPB;
  localparam logic [7:0] C = tmr_pkg::OFS_CON;
  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, res, e, c1, c2;
  logic [1:0] htrans = 2'b00, tin, timer_output_pin;
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [31:0] exp_q[$]; // expected results, oldest first
  event res_ev;
  int err_count = 0, checks_done = 0, seed = 32'hAB58, lo, per, n;
  always #5 mclk = ~mclk;
  tmr_unit i_tmr_unit (.mclk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tin, .timer_output_pin);
  tin_src i_tin_src (.mclk, .top(timer_output_pin), .tin);
  // watcher: pair each result with the oldest expectation
  always @(res_ev) begin
    e = exp_q.pop_front();
    checks_done++;
    if (res !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, res, e);
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask
  task automatic note(input logic [31:0] ex, input logic [31:0] r);
    exp_q.push_back(ex);
    res = r;
    ->res_ev;
    #1;
  endtask
  // one single AHB transfer; address held until hready, data held until hready
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d,
      output logic [31:0] r);
    int k;
    k = 0;
    @(posedge mclk);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) timeout();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0000, d};
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    r = hrdata;
    if (k >= 100) timeout();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic chk(input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] r;
    xfer(1'b0, idx, 16'h0000, r);
    note(ex, r);
  endtask
  // time an output low pulse, and optionally the fall-to-fall period
  task automatic span(input int p, input bit full, output int l, output int pr);
    int k;
    k = 0;
    while (timer_output_pin[p] !== 1'b0 && k < 300) begin @(posedge mclk); k++; end
    l = 0;
    while (timer_output_pin[p] === 1'b0 && k < 300) begin @(posedge mclk); l++; k++; end
    pr = l;
    while (full && timer_output_pin[p] !== 1'b0 && k < 300) begin
      @(posedge mclk);
      pr++;
      k++;
    end
    if (k >= 300) timeout();
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    // reset state and unmapped places
    note(32'h3, {30'h0, timer_output_pin});
    chk(T0 + C, 32'h0);
    wr(8'h80, 16'hFFFF);
    chk(8'h80, 32'h0);
    chk(8'h44, 32'h0);
    $display("test reset done");
    // timer 0 internal, repeating, limit 2, gate closed then open
    wr(T0 + A, 16'h0002);
    wr(T0 + C, 16'hC001); // en, inh, repeat
    repeat (20) @(posedge mclk);
    chk(T0, 32'h0);
    i_tin_src.level(0, 1'b1);
    span(0, 1'b1, lo, per);
    note(32'h1, lo);
    note(32'h8, per);
    chk(T0 + C, 32'h8021);
    wr(T0 + C, 16'h4000);
    $display("test single limit done");
    // dual limit, one-shot: B phase low for three events, then halt high
    wr(T0, 16'h0000);
    wr(T0 + B, 16'h0003);
    wr(T0 + C, 16'hC002);
    span(0, 1'b0, lo, per);
    note(32'hC, lo);
    repeat (30) @(posedge mclk);
    chk(T0 + C, 32'h0022);
    note(32'h1, {31'h0, timer_output_pin[0]});
    $display("test dual limit done");
    // timer 1 pin events, limit n
    n = 3 + ($unsigned($random(seed)) % 6);
    wr(T1, 16'h0000);
    wr(T1 + A, n[15:0]);
    wr(T1 + C, 16'hC004); // en, inh, ext
    i_tin_src.pulses(1, n - 1, 2 + ($unsigned($random(seed)) % 3), 2);
    // the last edge still needs synchronising, latching and its service slot
    repeat (8) @(posedge mclk);
    chk(T1, n - 1);
    fork
      i_tin_src.pulses(1, 1, 2, 2);
      span(1, 1'b0, lo, per);
    join
    note(32'h1, {31'h0, i_tin_src.lat >= 2 && i_tin_src.lat <= 6});
    chk(T1, 32'h0);
    wr(T1 + C, 16'h4004);
    i_tin_src.pulses(1, 3, 2, 2);
    chk(T1, 32'h0);
    $display("test pin events done");
    // timer 2 feeds timer 0
    wr(T2 + A, 16'h0003);
    wr(T2 + C, 16'hC01F);
    chk(T2 + C, 32'h8001);
    wr(T0, 16'h0000);
    wr(T0 + A, 16'h0000);
    wr(T0 + C, 16'hC009); // en, inh, chain, repeat
    xfer(1'b0, T0, 16'h0000, c1);
    repeat (120) @(posedge mclk);
    xfer(1'b0, T0, 16'h0000, c2);
    note(32'h1, {31'h0, (c2 - c1) >= 9 && (c2 - c1) <= 11});
    wr(T0 + C, 16'h4000);
    wr(T2 + C, 16'h4000);
    $display("test chaining done");
    // timer 1 retrigger: idle until the first edge, cleared by the next
    i_tin_src.level(1, 1'b0);
    wr(T1, 16'h0000);
    // a limit far above the counts seen here, so no wrap hides the restart
    wr(T1 + A, 16'h0100);
    wr(T1 + C, 16'hC011); // en, inh, restart_on_edge, repeat
    repeat (20) @(posedge mclk);
    chk(T1, 32'h0);
    i_tin_src.pulses(1, 1, 2, 2);
    repeat (40) @(posedge mclk);
    xfer(1'b0, T1, 16'h0000, c1);
    note(32'h1, {31'h0, c1 >= 8 && c1 <= 13});
    i_tin_src.pulses(1, 1, 2, 2);
    // let the retrigger edge reach its service slot before reading
    repeat (8) @(posedge mclk);
    xfer(1'b0, T1, 16'h0000, c2);
    note(32'h1, {31'h0, c2 < 4});
    $display("test retrigger done");
    // clock enable low freezes the running count
    xfer(1'b0, T1, 16'h0000, c1);
    ce <= 1'b0;
    repeat (20) @(posedge mclk);
    ce <= 1'b1;
    xfer(1'b0, T1, 16'h0000, c2);
    note(32'h1, {31'h0, (c2 - c1) <= 2});
    $display("test clock enable done");
    wrap_up();
  end
endmodule
